// file: core/clk_gen_map.svh
// Register offsets, field positions, reset values and timing figures of the clock bank
`ifndef CLK_GEN_MAP_SVH
`define CLK_GEN_MAP_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_BUS_DIV        32'h5000_0000
`define ADDR_TRIM           32'h5000_0002
`define ADDR_PERIPH         32'h5000_0004
`define ADDR_RADIO          32'h5000_0008

// ----------------------------------------------------------------
// Bus clock divider fields
// ----------------------------------------------------------------
`define BUS_CORE_DIV_LSB    0
`define BUS_APB_DIV_LSB     4
`define BUS_OTP_GATE_BIT    7

// ----------------------------------------------------------------
// Crystal trim fields
// ----------------------------------------------------------------
`define TRIM_FINE_LSB       0
`define TRIM_COARSE_LSB     8

// ----------------------------------------------------------------
// Peripheral clock fields
// ----------------------------------------------------------------
`define PER_FIRST_TIMER_CLOCK_DIVIDER_LSB     0
`define PER_TMR_GATE_BIT    3
`define PER_WAKE_GATE_BIT   4
`define PER_TWI_GATE_BIT    5
`define PER_SER2_GATE_BIT   6
`define PER_SER1_GATE_BIT   7
`define PER_SPI_DIV_LSB     8
`define PER_SPI_GATE_BIT    11
`define PER_QUAD_GATE_BIT   15

// ----------------------------------------------------------------
// Radio clock fields
// ----------------------------------------------------------------
`define RAD_RF_CONTROL_UNIT_CLOCK_DIVIDER_LSB    0
`define RAD_RFCU_GATE_BIT   3
`define RAD_LINK_DIV_LSB    4
`define RAD_LPT_RESET_BIT   6
`define RAD_LINK_GATE_BIT   7

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define DIV_BY_1            2'h0
`define DIV_BY_4            2'h2
`define GATE_OFF            1'b0
`define LPT_RESET_INIT      1'b1
`define FINE_TRIM_INIT      8'h00
`define COARSE_TRIM_INIT    3'h0
`define SRC_SEL_XTAL        2'h0
`define SRC_SEL_RC          2'h1
`define RDATA_ZERO          16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SETTLE_TIME_US      200
`define CLK_FREQ_MHZ        40

`endif

// file: core/clk_gen_pkg.sv
// Types shared by the clock divider and gate bank
package clk_gen_pkg;

   typedef logic [1:0] div_sel_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic xtal;
      logic rc;
      logic low;
   } source_ticks_t;

   typedef struct packed {
      logic core;
      logic apb;
      logic otp;
      logic quad;
      logic spi;
      logic serial1;
      logic serial2;
      logic twoWire;
      logic wakeCapture;
      logic first_general_timer;
      logic second_general_timer;
      logic linkCore;
      logic rfControl;
   } clock_ticks_t;

   typedef enum {
      TRIM_IDLE,
      TRIM_SETTLING
   } trim_state_t;

endpackage

// file: core/clock_div_stage.sv
// Power-of-two tick divider stage selected by a 2-bit code
`timescale 1ns/100ps
module clock_div_stage #(
   parameter int CNT_W = 3
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 syncClear,
   // Tick in and out
   input  wire logic                 inTick,
   input  wire clk_gen_pkg::div_sel_t divSel,
   output logic                      outTick
);
   import clk_gen_pkg::*;

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] mask;

   // ----------------------------------------------------------------
   // Divide by 1, 2, 4 or 8
   // ----------------------------------------------------------------
   always_comb begin
      mask    = ~({CNT_W{1'b1}} << divSel);
      outTick = inTick & ((count_r & mask) == mask);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= '0;
      end else if (syncClear) begin
         count_r <= '0;
      end else if (inTick) begin
         count_r <= count_r + 1'b1;
      end
   end

endmodule

// file: core/clock_divider_gate_bank.sv
// Clock divider and gate bank with crystal trim and link timer reset control
//
// What this block does
// R1 - Core clock is source divided by 1, 2, 4, 8; resets to four.
// R2 - APB clock divides the core clock by 1, 2, 4, 8; resets to four.
// R3 - Bus register bit 7 gates the OTP controller clock, off at reset.
// R4 - Three-bit coarse crystal trim, zero lowest frequency, seven highest.
// R5 - Software steps coarse trim by one and waits about 200 us.
// R6 - Eight-bit fine crystal trim, zero lowest frequency, all ones highest.
// R7 - Peripheral bit 15 gates the quadrature decoder clock, off at reset.
// R8 - SPI clock gated by bit 11, divided per bits 9:8, reset divide-by-one.
// R9 - Peripheral bit 4 gates the wakeup capture timer clock, off at reset.
// R10 - Peripheral bit 3 gates both general timers together, off at reset.
// R11 - First timer clock divided per peripheral bits 1:0, reset divide-by-one.
// R12 - Bits 7, 6, 5 gate serial one, serial two, two-wire bus clocks.
// R13 - Radio bit 7 gates all link-layer core clocks, off at reset.
// R14 - Radio bit 6 holds link low-power timer in reset; resets set.
// R15 - Link core clock divided per radio bits 5:4, reset divide-by-one.
// R16 - Software keeps link core clock at least 8 MHz, not above core.
// R17 - Radio bit 3 gates the RF control unit clock, off at reset.
// R18 - RF control unit divided per bits 1:0; software picks exactly 8 MHz.
// R19 - Source selector: 0 crystal, 1 RC oscillator, 2 or 3 slow source.
// R20 - Software device reset restores reset values in all registers except the crystal trim.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "clk_gen_map.svh"
module clock_divider_gate_bank #(
   parameter int SETTLE_CYCLES = `SETTLE_TIME_US * `CLK_FREQ_MHZ,
   parameter int SETTLE_W      = 14
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   // Register port
   input  wire clk_gen_pkg::reg_req_t     regReq,
   output logic [15:0]                    regRdata,
   // Source selection and software reset
   input  wire logic [1:0]                sourceClockSelector,
   input  wire logic                      softwareDeviceReset,
   // Source clock ticks
   input  wire clk_gen_pkg::source_ticks_t sourceTicks,
   // Derived clock enables
   output clk_gen_pkg::clock_ticks_t      clockTicks,
   // Crystal trim
   output logic [2:0]                     crystalCoarseTrim,
   output logic [7:0]                     crystalFineTrim,
   output logic                           crystalTrimSettling,
   // Link low-power timer
   output logic                           linkLowPowerTimerReset
);
   import clk_gen_pkg::*;

   localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   div_sel_t    coreDiv_r;
   div_sel_t    apbDiv_r;
   logic        otpGate_r;
   logic [2:0]  crystal_coarse_trim_r;
   logic [7:0]  crystal_fine_trim_r;
   logic        quadGate_r;
   logic        spiGate_r;
   div_sel_t    spiDiv_r;
   logic        first_serial_port_clock_gate_r;
   logic        second_serial_port_clock_gate_r;
   logic        twoWireGate_r;
   logic        wake_capture_timer_clock_gate_r;
   logic        general_timers_clock_gate_r;
   div_sel_t    first_timer_clock_divider_r;
   logic        link_layer_core_clock_gate_r;
   logic        link_low_power_timer_reset_r;
   div_sel_t    link_layer_core_clock_divider_r;
   logic        rf_control_unit_clock_gate_r;
   div_sel_t    rf_control_unit_clock_divider_r;

   logic        wrBus;
   logic        wrTrim;
   logic        wrPeriph;
   logic        wrRadio;
   logic [15:0] rdata_nxt;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   always_comb begin
      wrBus    = regReq.wr & (regReq.addr == `ADDR_BUS_DIV);
      wrTrim   = regReq.wr & (regReq.addr == `ADDR_TRIM);
      wrPeriph = regReq.wr & (regReq.addr == `ADDR_PERIPH);
      wrRadio  = regReq.wr & (regReq.addr == `ADDR_RADIO);
   end

   // ----------------------------------------------------------------
   // Bus clock divider register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         coreDiv_r <= `DIV_BY_4;
         apbDiv_r  <= `DIV_BY_4;
         otpGate_r <= `GATE_OFF;
      end else if (softwareDeviceReset) begin
         coreDiv_r <= `DIV_BY_4; // R20
         apbDiv_r  <= `DIV_BY_4;
         otpGate_r <= `GATE_OFF;
      end else if (wrBus) begin
         coreDiv_r <= regReq.wdata[`BUS_CORE_DIV_LSB +: 2]; // R1
         apbDiv_r  <= regReq.wdata[`BUS_APB_DIV_LSB +: 2]; // R2
         otpGate_r <= regReq.wdata[`BUS_OTP_GATE_BIT]; // R3
      end
   end

   // ----------------------------------------------------------------
   // Crystal trim register
   // ----------------------------------------------------------------
   // Survives the software reset so the oscillator keeps its tuning
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         crystal_coarse_trim_r <= `COARSE_TRIM_INIT;
         crystal_fine_trim_r   <= `FINE_TRIM_INIT;
      end else if (wrTrim) begin
         crystal_coarse_trim_r <= regReq.wdata[`TRIM_COARSE_LSB +: 3]; // R4
         crystal_fine_trim_r   <= regReq.wdata[`TRIM_FINE_LSB +: 8]; // R6
      end
   end

   // ----------------------------------------------------------------
   // Peripheral clock register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         quadGate_r                      <= `GATE_OFF;
         spiGate_r                       <= `GATE_OFF;
         spiDiv_r                        <= `DIV_BY_1;
         first_serial_port_clock_gate_r  <= `GATE_OFF;
         second_serial_port_clock_gate_r <= `GATE_OFF;
         twoWireGate_r                   <= `GATE_OFF;
         wake_capture_timer_clock_gate_r <= `GATE_OFF;
         general_timers_clock_gate_r     <= `GATE_OFF;
         first_timer_clock_divider_r     <= `DIV_BY_1;
      end else if (softwareDeviceReset) begin
         quadGate_r                      <= `GATE_OFF; // R20
         spiGate_r                       <= `GATE_OFF;
         spiDiv_r                        <= `DIV_BY_1;
         first_serial_port_clock_gate_r  <= `GATE_OFF;
         second_serial_port_clock_gate_r <= `GATE_OFF;
         twoWireGate_r                   <= `GATE_OFF;
         wake_capture_timer_clock_gate_r <= `GATE_OFF;
         general_timers_clock_gate_r     <= `GATE_OFF;
         first_timer_clock_divider_r     <= `DIV_BY_1;
      end else if (wrPeriph) begin
         quadGate_r                      <= regReq.wdata[`PER_QUAD_GATE_BIT]; // R7
         spiGate_r                       <= regReq.wdata[`PER_SPI_GATE_BIT]; // R8
         spiDiv_r                        <= regReq.wdata[`PER_SPI_DIV_LSB +: 2]; // R8
         first_serial_port_clock_gate_r  <= regReq.wdata[`PER_SER1_GATE_BIT]; // R12
         second_serial_port_clock_gate_r <= regReq.wdata[`PER_SER2_GATE_BIT]; // R12
         twoWireGate_r                   <= regReq.wdata[`PER_TWI_GATE_BIT]; // R12
         wake_capture_timer_clock_gate_r <= regReq.wdata[`PER_WAKE_GATE_BIT]; // R9
         general_timers_clock_gate_r     <= regReq.wdata[`PER_TMR_GATE_BIT]; // R10
         first_timer_clock_divider_r     <= regReq.wdata[`PER_FIRST_TIMER_CLOCK_DIVIDER_LSB +: 2]; // R11
      end
   end

   // ----------------------------------------------------------------
   // Radio clock register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         link_layer_core_clock_gate_r    <= `GATE_OFF;
         link_low_power_timer_reset_r    <= `LPT_RESET_INIT;
         link_layer_core_clock_divider_r <= `DIV_BY_1;
         rf_control_unit_clock_gate_r    <= `GATE_OFF;
         rf_control_unit_clock_divider_r <= `DIV_BY_1;
      end else if (softwareDeviceReset) begin
         link_layer_core_clock_gate_r    <= `GATE_OFF; // R20
         link_low_power_timer_reset_r    <= `LPT_RESET_INIT;
         link_layer_core_clock_divider_r <= `DIV_BY_1;
         rf_control_unit_clock_gate_r    <= `GATE_OFF;
         rf_control_unit_clock_divider_r <= `DIV_BY_1;
      end else if (wrRadio) begin
         link_layer_core_clock_gate_r    <= regReq.wdata[`RAD_LINK_GATE_BIT]; // R13
         link_low_power_timer_reset_r    <= regReq.wdata[`RAD_LPT_RESET_BIT]; // R14
         link_layer_core_clock_divider_r <= regReq.wdata[`RAD_LINK_DIV_LSB +: 2]; // R15
         rf_control_unit_clock_gate_r    <= regReq.wdata[`RAD_RFCU_GATE_BIT]; // R17
         rf_control_unit_clock_divider_r <= regReq.wdata[`RAD_RF_CONTROL_UNIT_CLOCK_DIVIDER_LSB +: 2]; // R18
      end
   end

   // ----------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = `RDATA_ZERO;
      unique case (regReq.addr)
         `ADDR_BUS_DIV: begin
            rdata_nxt[`BUS_CORE_DIV_LSB +: 2] = coreDiv_r;
            rdata_nxt[`BUS_APB_DIV_LSB +: 2]  = apbDiv_r;
            rdata_nxt[`BUS_OTP_GATE_BIT]      = otpGate_r;
         end
         `ADDR_TRIM: begin
            rdata_nxt[`TRIM_COARSE_LSB +: 3] = crystal_coarse_trim_r;
            rdata_nxt[`TRIM_FINE_LSB +: 8]   = crystal_fine_trim_r;
         end
         `ADDR_PERIPH: begin
            rdata_nxt[`PER_QUAD_GATE_BIT]     = quadGate_r;
            rdata_nxt[`PER_SPI_GATE_BIT]      = spiGate_r;
            rdata_nxt[`PER_SPI_DIV_LSB +: 2]  = spiDiv_r;
            rdata_nxt[`PER_SER1_GATE_BIT]     = first_serial_port_clock_gate_r;
            rdata_nxt[`PER_SER2_GATE_BIT]     = second_serial_port_clock_gate_r;
            rdata_nxt[`PER_TWI_GATE_BIT]      = twoWireGate_r;
            rdata_nxt[`PER_WAKE_GATE_BIT]     = wake_capture_timer_clock_gate_r;
            rdata_nxt[`PER_TMR_GATE_BIT]      = general_timers_clock_gate_r;
            rdata_nxt[`PER_FIRST_TIMER_CLOCK_DIVIDER_LSB +: 2]  = first_timer_clock_divider_r;
         end
         `ADDR_RADIO: begin
            rdata_nxt[`RAD_LINK_GATE_BIT]     = link_layer_core_clock_gate_r;
            rdata_nxt[`RAD_LPT_RESET_BIT]     = link_low_power_timer_reset_r;
            rdata_nxt[`RAD_LINK_DIV_LSB +: 2] = link_layer_core_clock_divider_r;
            rdata_nxt[`RAD_RFCU_GATE_BIT]     = rf_control_unit_clock_gate_r;
            rdata_nxt[`RAD_RF_CONTROL_UNIT_CLOCK_DIVIDER_LSB +: 2] = rf_control_unit_clock_divider_r;
         end
         default: begin
            rdata_nxt = `RDATA_ZERO;
         end
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdata <= `RDATA_ZERO;
      end else if (regReq.rd) begin
         regRdata <= rdata_nxt;
      end else begin
         regRdata <= `RDATA_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // Source selection
   // ----------------------------------------------------------------
   logic srcTick;

   always_comb begin
      unique case (sourceClockSelector)
         `SRC_SEL_XTAL: srcTick = sourceTicks.xtal; // R19
         `SRC_SEL_RC:   srcTick = sourceTicks.rc; // R19
         default:       srcTick = sourceTicks.low; // R19
      endcase
   end

   // ----------------------------------------------------------------
   // Divider stages
   // ----------------------------------------------------------------
   // Counters restart on software reset so every divided clock re-aligns
   logic coreTick;
   logic apbTick;
   logic spiTick;
   logic timer0Tick;
   logic linkTick;
   logic rfcuTick;

   clock_div_stage #(.CNT_W(3)) coreStage (.clk(clk), .sys_rst(sys_rst), .syncClear(softwareDeviceReset),
      .inTick(srcTick), .divSel(coreDiv_r), .outTick(coreTick)); // R1

   // Cascaded on the core tick, not the source
   clock_div_stage #(.CNT_W(3)) apbStage (.clk(clk), .sys_rst(sys_rst), .syncClear(softwareDeviceReset),
      .inTick(coreTick), .divSel(apbDiv_r), .outTick(apbTick)); // R2

   clock_div_stage #(.CNT_W(3)) spiStage (.clk(clk), .sys_rst(sys_rst), .syncClear(softwareDeviceReset),
      .inTick(srcTick), .divSel(spiDiv_r), .outTick(spiTick)); // R8

   clock_div_stage #(.CNT_W(3)) timerStage (.clk(clk), .sys_rst(sys_rst), .syncClear(softwareDeviceReset),
      .inTick(srcTick), .divSel(first_timer_clock_divider_r), .outTick(timer0Tick)); // R11

   // No check that the result meets the 8 MHz floor; software owns that
   clock_div_stage #(.CNT_W(3)) linkStage (.clk(clk), .sys_rst(sys_rst), .syncClear(softwareDeviceReset),
      .inTick(srcTick), .divSel(link_layer_core_clock_divider_r), .outTick(linkTick)); // R15

   clock_div_stage #(.CNT_W(3)) rfcuStage (.clk(clk), .sys_rst(sys_rst), .syncClear(softwareDeviceReset),
      .inTick(srcTick), .divSel(rf_control_unit_clock_divider_r), .outTick(rfcuTick)); // R18

   // ----------------------------------------------------------------
   // Clock enables, gated for all but core and APB
   // ----------------------------------------------------------------
   // Registered so that gating never chops a tick mid-cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clockTicks <= '0;
      end else begin
         clockTicks.core        <= coreTick; // R1
         clockTicks.apb         <= apbTick; // R2
         clockTicks.otp         <= coreTick & otpGate_r; // R3
         clockTicks.quad        <= srcTick & quadGate_r; // R7
         clockTicks.spi         <= spiTick & spiGate_r; // R8
         clockTicks.serial1     <= srcTick & first_serial_port_clock_gate_r; // R12
         clockTicks.serial2     <= srcTick & second_serial_port_clock_gate_r; // R12
         clockTicks.twoWire     <= srcTick & twoWireGate_r; // R12
         clockTicks.wakeCapture <= srcTick & wake_capture_timer_clock_gate_r; // R9
         clockTicks.first_general_timer      <= timer0Tick & general_timers_clock_gate_r; // R10
         clockTicks.second_general_timer      <= srcTick & general_timers_clock_gate_r; // R10
         clockTicks.linkCore    <= linkTick & link_layer_core_clock_gate_r; // R13
         clockTicks.rfControl   <= rfcuTick & rf_control_unit_clock_gate_r; // R17
      end
   end

   // ----------------------------------------------------------------
   // Trim and timer reset outputs
   // ----------------------------------------------------------------
   always_comb begin
      crystalCoarseTrim      = crystal_coarse_trim_r; // R4
      crystalFineTrim        = crystal_fine_trim_r; // R6
      linkLowPowerTimerReset = link_low_power_timer_reset_r; // R14
   end

   // ----------------------------------------------------------------
   // Coarse trim settle tracker
   // ----------------------------------------------------------------
   // Only reports; a too-early step is not blocked
   trim_state_t         trimState_r;
   logic [SETTLE_W-1:0] settleCount_r;
   logic                coarseChange;

   always_comb begin
      coarseChange = wrTrim &
                     (regReq.wdata[`TRIM_COARSE_LSB +: 3] != crystal_coarse_trim_r);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trimState_r   <= TRIM_IDLE;
         settleCount_r <= '0;
      end else if (coarseChange) begin
         trimState_r   <= TRIM_SETTLING; // R5
         settleCount_r <= '0;
      end else begin
         unique case (trimState_r)
            TRIM_IDLE: begin
               settleCount_r <= '0;
            end
            TRIM_SETTLING: begin
               if (settleCount_r == SETTLE_LAST) begin
                  trimState_r   <= TRIM_IDLE;
                  settleCount_r <= '0;
               end else begin
                  settleCount_r <= settleCount_r + 1'b1;
               end
            end
         endcase
      end
   end

   always_comb begin
      crystalTrimSettling = (trimState_r == TRIM_SETTLING);
   end

endmodule

// file: bench/clock_divider_gate_bank_chk.sv
// Port checker for the clock divider and gate bank
`timescale 1ns/100ps
`include "clk_gen_map.svh"
module clock_divider_gate_bank_chk (
   // Clock and reset
   input wire logic                       clk,
   input wire logic                       sys_rst,
   // Observed ports
   input wire clk_gen_pkg::reg_req_t      regReq,
   input wire logic [1:0]                 sourceClockSelector,
   input wire logic                       softwareDeviceReset,
   input wire clk_gen_pkg::source_ticks_t sourceTicks,
   input wire clk_gen_pkg::clock_ticks_t  clockTicks,
   input wire logic [2:0]                 crystalCoarseTrim,
   input wire logic [7:0]                 crystalFineTrim,
   input wire logic                       linkLowPowerTimerReset
);
   import clk_gen_pkg::*;
   logic selTick;
   assign selTick = (sourceClockSelector == 2'h0) ? sourceTicks.xtal :
                    (sourceClockSelector == 2'h1) ? sourceTicks.rc : sourceTicks.low;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_core; clockTicks.core |-> $past(selTick); endproperty
   a_core: assert property (p_core) else $error("core tick without source tick");
   property p_otp; clockTicks.otp |-> clockTicks.core; endproperty
   a_otp: assert property (p_otp) else $error("otp tick apart from core tick");
   property p_quad; clockTicks.quad |-> $past(selTick); endproperty
   a_quad: assert property (p_quad) else $error("quad tick without source tick");
   property p_tmr; clockTicks.second_general_timer |-> $past(selTick); endproperty
   a_tmr: assert property (p_tmr) else $error("timer tick without source tick");
   property p_fine; $changed(crystalFineTrim) |-> $past(regReq.wr) && $past(regReq.addr) == `ADDR_TRIM
      && crystalFineTrim == $past(regReq.wdata[7:0]); endproperty
   a_fine: assert property (p_fine) else $error("fine trim changed without trim write");
   property p_coarse; $changed(crystalCoarseTrim) |-> $past(regReq.wr) && $past(regReq.addr) == `ADDR_TRIM
      && crystalCoarseTrim == $past(regReq.wdata[10:8]); endproperty
   a_coarse: assert property (p_coarse) else $error("coarse trim changed without trim write");
   property p_lpt; $rose(linkLowPowerTimerReset) |-> $past(softwareDeviceReset) || ($past(regReq.wr)
      && $past(regReq.addr) == `ADDR_RADIO && $past(regReq.wdata[6])); endproperty
   a_lpt: assert property (p_lpt) else $error("timer reset rose without cause");
   property p_swr; softwareDeviceReset |-> ##2 !clockTicks.quad && linkLowPowerTimerReset; endproperty
   a_swr: assert property (p_swr) else $error("software reset left gate or timer state");
   c_core: cover property (clockTicks.core);
   c_quad: cover property (clockTicks.quad);
   c_link: cover property (clockTicks.linkCore);
endmodule
bind clock_divider_gate_bank clock_divider_gate_bank_chk u_chk (.clk, .sys_rst, .regReq, .sourceClockSelector,
   .softwareDeviceReset, .sourceTicks, .clockTicks, .crystalCoarseTrim, .crystalFineTrim, .linkLowPowerTimerReset);

// file: bench/clock_divider_gate_bank_test.sv
// Self-checking bench for the clock divider and gate bank
`timescale 1ns/100ps
`include "clk_gen_map.svh"
module clock_divider_gate_bank_test;
   import clk_gen_pkg::*;
   logic          clk, sys_rst, swRst, settling, lptReset;
   reg_req_t      req;
   logic [15:0]   rdata;
   logic [1:0]    sel;
   source_ticks_t src;
   clock_ticks_t  ticks;
   logic [2:0]    coarse;
   logic [7:0]    fine;
   int            n_mismatch, total_checks;
   clock_divider_gate_bank #(.SETTLE_CYCLES(16)) dut (.clk(clk), .sys_rst(sys_rst), .regReq(req),
      .regRdata(rdata), .sourceClockSelector(sel), .softwareDeviceReset(swRst), .sourceTicks(src),
      .clockTicks(ticks), .crystalCoarseTrim(coarse), .crystalFineTrim(fine),
      .crystalTrimSettling(settling), .linkLowPowerTimerReset(lptReset));
   task automatic cmp(string nm, logic [15:0] exp, logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [31:0] a, logic [15:0] d);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [31:0] a, logic [15:0] exp);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 cmp("read data", exp, rdata);
      @(posedge clk);
   endtask
   // Write, read back, count a tick over 64 cycles
   task automatic chk(logic [31:0] a, logic [15:0] d, int b, int exp);
      int n = 0;
      wr(a, d);
      rd(a, d);
      repeat (3) @(posedge clk);
      repeat (64) begin
         @(posedge clk);
         #1 n += ticks[b];
      end
      cmp("tick count", 16'(exp), 16'(n));
      @(posedge clk);
   endtask
   task automatic t_reset();
      rd(`ADDR_BUS_DIV, 16'h0022);
      rd(`ADDR_TRIM, 16'h0000);
      rd(`ADDR_PERIPH, 16'h0000);
      rd(`ADDR_RADIO, 16'h0040);
      cmp("timer reset", 16'h0001, {15'h0000, lptReset});
      wr(32'h5000_0006, 16'hFFFF);
      rd(32'h5000_0006, 16'h0000);
   endtask
   task automatic t_bus();
      chk(`ADDR_BUS_DIV, 16'h0000, 12, 64);
      chk(`ADDR_BUS_DIV, 16'h0001, 12, 32);
      chk(`ADDR_BUS_DIV, 16'h0003, 12, 8);
      chk(`ADDR_BUS_DIV, 16'h0030, 11, 8);
      chk(`ADDR_BUS_DIV, 16'h0011, 11, 16);
      chk(`ADDR_BUS_DIV, 16'h0080, 10, 64);
      chk(`ADDR_BUS_DIV, 16'h0081, 10, 32);
   endtask
   task automatic t_periph();
      chk(`ADDR_PERIPH, 16'h8000, 9, 64);
      chk(`ADDR_PERIPH, 16'h0000, 9, 0);
      chk(`ADDR_PERIPH, 16'h0A00, 8, 16);
      chk(`ADDR_PERIPH, 16'h0300, 8, 0);
      chk(`ADDR_PERIPH, 16'h0010, 4, 64);
      chk(`ADDR_PERIPH, 16'h0008, 2, 64);
      chk(`ADDR_PERIPH, 16'h000B, 3, 8);
      chk(`ADDR_PERIPH, 16'h0003, 3, 0);
      chk(`ADDR_PERIPH, 16'h0080, 7, 64);
      chk(`ADDR_PERIPH, 16'h0040, 6, 64);
      chk(`ADDR_PERIPH, 16'h0020, 5, 64);
   endtask
   task automatic t_radio();
      chk(`ADDR_RADIO, 16'h0090, 1, 32);
      chk(`ADDR_RADIO, 16'h0010, 1, 0);
      chk(`ADDR_RADIO, 16'h0009, 0, 32);
      chk(`ADDR_RADIO, 16'h0001, 0, 0);
      cmp("timer reset", 16'h0000, {15'h0000, lptReset});
   endtask
   // Trim survives the soft reset
   task automatic t_trim();
      wr(`ADDR_TRIM, 16'hF9FF);
      rd(`ADDR_TRIM, 16'h01FF);
      cmp("trim", 16'h81FF, {settling, 4'h0, coarse, fine});
      swRst <= 1'b1;
      @(posedge clk);
      swRst <= 1'b0;
      @(posedge clk);
      rd(`ADDR_TRIM, 16'h01FF);
      rd(`ADDR_RADIO, 16'h0040);
      cmp("timer reset", 16'h0001, {15'h0000, lptReset});
   endtask
   task automatic t_source();
      sel <= 2'h1;
      src <= 3'b101;
      chk(`ADDR_BUS_DIV, 16'h0000, 12, 0);
      cmp("settling", 16'h0000, {15'h0000, settling});
      src <= 3'b010;
      chk(`ADDR_BUS_DIV, 16'h0000, 12, 64);
      sel <= 2'h2;
      src <= 3'b001;
      chk(`ADDR_BUS_DIV, 16'h0000, 12, 64);
   endtask
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // About 1830 cycles expected
   initial begin
      #200_000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      sys_rst = 1'b1;
      swRst = 1'b0;
      req = '0;
      sel = 2'h0;
      src = 3'b111;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_bus();
      t_periph();
      t_radio();
      t_trim();
      t_source();
      end_of_test();
   end
endmodule
